// File: rtl/ppc_regs.sv
// Purpose: Register front end of a PC-compatible printer port
// Assumes: Host strobes are synchronous one-cycle pulses; cable inputs synchronous
// Notes: EPP handshake is reduced to a busy window with a watchdog
// Overview of operation
// - Reset clears data; writes drive lines
// - Data read returns live line levels
// - Status captured at read start, held
// - Timeout bit, EPP only, reset clears
// - Clear mode: on read end or write
// - Write one clears flag; zero ignored
// - Hard reset always clears timeout flag
// - Status bits one, two read zero
// - Bit three shows fault input level
// - Bit four shows online input level
// - Bit five shows paper-out level
// - Bit six shows acknowledge level
// - Bit seven is inverted busy input
// - Reset control bits 0-5; 6,7 zero
// - Strobe pin is inverted control bit 0
// - Autofeed pin is inverted bit 1
// - Init pin follows bit 2 directly
// - Select-in pin is inverted bit 3
// - Enabled ack rising edge raises interrupt
// - Bit five sets direction except printer
// - Decode eight ports; EPP ports EPP-only
// - Status writable in EPP; others RW
// - EPP cycle over 10us aborts, flags
`timescale 1ns/100ps
`default_nettype none
module ppc_regs (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic [15:0] base_addr_i,
    input wire logic [1:0] mode_i,
    input wire logic timeout_clear_mode_i,
    // Host I/O port
    input wire logic [15:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic host_rd_end_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic host_hit_o,
    // Cable data lines
    input wire logic [7:0] port_data_lines_i,
    output logic [7:0] port_data_lines_o,
    output logic port_data_lines_oe_o,
    // Cable status inputs
    input wire logic fault_in_level_i,
    input wire logic online_in_level_i,
    input wire logic paper_out_level_i,
    input wire logic ack_in_level_i,
    input wire logic busy_in_i,
    input wire logic epp_wait_low_i,
    // Cable control outputs
    output logic strobe_out_low_o,
    output logic autofeed_out_low_o,
    output logic peripheral_reset_out_o,
    output logic select_request_out_o,
    // Interrupt request and EPP cycle
    output logic port_irq_o,
    output logic epp_busy_o
);
    logic [7:0] port_data_latch_reg;
    logic [5:0] peripheral_control_reg;
    logic timeout_flag_reg;
    logic [7:0] status_hold_reg;
    logic read_active_reg;
    logic ack_prev_reg;
    logic [7:0] epp_latch_reg;
    logic [ppc_pkg::WD_WIDTH-1:0] wd_count_reg;
    logic hit;
    logic [2:0] off;
    logic epp_mode;
    logic epp_reg_sel;
    logic [7:0] status_live;
    logic data_dir_in;
    logic wd_expire;
    logic [16:0] addr_diff;

    localparam logic [ppc_pkg::WD_WIDTH-1:0] WD_LIMIT =
        ppc_pkg::WD_WIDTH'(ppc_pkg::EPP_TIMEOUT_CYCLES - 1);
    localparam logic [16:0] WINDOW_SIZE = 17'(ppc_pkg::WINDOW_BYTES);

    // Window decode; EPP ports vanish outside EPP mode
    assign addr_diff = {1'b0, host_addr_i} - {1'b0, base_addr_i};
    assign off = addr_diff[2:0];
    assign epp_mode = (mode_i == ppc_pkg::PPC_MODE_EPP);
    assign epp_reg_sel = (off >= ppc_pkg::OFF_EPP_ADDR);
    assign hit = (addr_diff < WINDOW_SIZE) && (epp_mode || !epp_reg_sel);
    assign wd_expire = epp_busy_o && (wd_count_reg == WD_LIMIT);

    // Live status byte; bits 1 and 2 have no storage
    always_comb begin
        status_live = 8'h00;
        status_live[ppc_pkg::ST_TIMEOUT] = timeout_flag_reg && epp_mode;
        status_live[ppc_pkg::ST_FAULT] = fault_in_level_i;
        status_live[ppc_pkg::ST_ONLINE] = online_in_level_i;
        status_live[ppc_pkg::ST_PAPER] = paper_out_level_i;
        status_live[ppc_pkg::ST_ACK] = ack_in_level_i;
        status_live[ppc_pkg::ST_READY] = !busy_in_i;
    end

    // Printer mode forces output regardless of the direction bit
    assign data_dir_in = (mode_i != ppc_pkg::PPC_MODE_PRINTER) &&
        peripheral_control_reg[ppc_pkg::CT_DIRECTION];

    // Data latch
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            port_data_latch_reg <= ppc_pkg::DATA_RESET;
        end else if (host_wr_i && hit && off == ppc_pkg::OFF_DATA) begin
            port_data_latch_reg <= host_wdata_i;
        end
    end

    // Control register; top two bits are wired low
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            peripheral_control_reg <= ppc_pkg::CONTROL_RESET;
        end else if (host_wr_i && hit && off == ppc_pkg::OFF_CONTROL) begin
            peripheral_control_reg <= host_wdata_i[ppc_pkg::CT_WIDTH-1:0];
        end
    end

    // EPP cycle: write latches the byte, watchdog bounds the wait on the peripheral
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            epp_busy_o <= 1'b0;
            wd_count_reg <= '0;
            epp_latch_reg <= 8'h00;
        end else if (epp_busy_o) begin
            wd_count_reg <= wd_count_reg + 1'b1;
            if (!epp_wait_low_i || wd_expire) begin
                epp_busy_o <= 1'b0;
            end
        end else if ((host_wr_i || host_rd_i) && hit && epp_reg_sel) begin
            epp_busy_o <= 1'b1;
            wd_count_reg <= '0;
            if (host_wr_i) begin
                epp_latch_reg <= host_wdata_i;
            end
        end
    end

    // Timeout flag; a new timeout wins over a read-end or write clear in the same cycle, reset wins over both
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            timeout_flag_reg <= 1'b0;
        end else if (wd_expire) begin
            timeout_flag_reg <= 1'b1;
        end else if (!timeout_clear_mode_i && host_rd_end_i && read_active_reg) begin
            timeout_flag_reg <= 1'b0;
        end else if (timeout_clear_mode_i && host_wr_i && hit && epp_mode &&
                     off == ppc_pkg::OFF_STATUS && host_wdata_i[ppc_pkg::ST_TIMEOUT]) begin
            timeout_flag_reg <= 1'b0;
        end
    end

    // Status snapshot held for the whole read cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            read_active_reg <= 1'b0;
            status_hold_reg <= 8'h00;
        end else if (host_rd_i && hit && off == ppc_pkg::OFF_STATUS) begin
            read_active_reg <= 1'b1;
            status_hold_reg <= status_live;
        end else if (host_rd_end_i) begin
            read_active_reg <= 1'b0;
        end
    end

    // Read data; registered so the output is a flop
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            host_rdata_o <= 8'h00;
            host_hit_o <= 1'b0;
        end else begin
            host_hit_o <= host_rd_i && hit;
            if (host_rd_i && hit) begin
                unique case (off)
                    ppc_pkg::OFF_DATA: host_rdata_o <= port_data_lines_i;
                    ppc_pkg::OFF_STATUS: host_rdata_o <= status_live;
                    ppc_pkg::OFF_CONTROL: host_rdata_o <= {2'b00, peripheral_control_reg};
                    default: host_rdata_o <= port_data_lines_i;
                endcase
            end else if (!read_active_reg) begin
                host_rdata_o <= 8'h00;
            end
        end
    end

    // Pin drive; EPP byte shown while a cycle runs
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            port_data_lines_o <= 8'h00;
            port_data_lines_oe_o <= 1'b1;
            strobe_out_low_o <= 1'b1;
            autofeed_out_low_o <= 1'b1;
            peripheral_reset_out_o <= 1'b0;
            select_request_out_o <= 1'b1;
        end else begin
            port_data_lines_o <= epp_busy_o ? epp_latch_reg : port_data_latch_reg;
            port_data_lines_oe_o <= !data_dir_in;
            strobe_out_low_o <= !peripheral_control_reg[ppc_pkg::CT_STROBE];
            autofeed_out_low_o <= !peripheral_control_reg[ppc_pkg::CT_AUTOFEED];
            peripheral_reset_out_o <= peripheral_control_reg[ppc_pkg::CT_PERIPH_RESET];
            select_request_out_o <= !peripheral_control_reg[ppc_pkg::CT_SELECT];
        end
    end

    // Interrupt: one-cycle pulse on ack rising edge when enabled
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ack_prev_reg <= 1'b1; // Idle level of the active-low ack, so no false edge after reset
            port_irq_o <= 1'b0;
        end else begin
            ack_prev_reg <= ack_in_level_i;
            port_irq_o <= peripheral_control_reg[ppc_pkg::CT_IRQ_EN] &&
                ack_in_level_i && !ack_prev_reg;
        end
    end

    // Status read returns the held snapshot one edge later
    property p_status_read;
        @(posedge clock_i) disable iff (!rstn_i)
        (host_rd_i && hit && off == ppc_pkg::OFF_STATUS) |=> (host_rdata_o == status_hold_reg);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read mismatch");

    property p_data_reset;
        @(posedge clock_i) $rose(rstn_i) |-> (port_data_latch_reg == 8'h00);
    endproperty
    a_data_reset: assert property (p_data_reset) else $error("data latch not cleared");

    property p_strobe;
        @(posedge clock_i) disable iff (!rstn_i)
        ##1 (strobe_out_low_o == !$past(peripheral_control_reg[ppc_pkg::CT_STROBE]));
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pin wrong");

    property p_init;
        @(posedge clock_i) disable iff (!rstn_i)
        ##1 (peripheral_reset_out_o == $past(peripheral_control_reg[ppc_pkg::CT_PERIPH_RESET]));
    endproperty
    a_init: assert property (p_init) else $error("init pin wrong");

    property p_irq;
        @(posedge clock_i) disable iff (!rstn_i)
        port_irq_o |-> $past(peripheral_control_reg[ppc_pkg::CT_IRQ_EN]) && $past(ack_in_level_i, 1)
            && !$past(ack_in_level_i, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("spurious interrupt");

    property p_printer_out;
        @(posedge clock_i) disable iff (!rstn_i)
        (mode_i == ppc_pkg::PPC_MODE_PRINTER) |=> port_data_lines_oe_o;
    endproperty
    a_printer_out: assert property (p_printer_out) else $error("printer mode not driving");

    property p_timeout_set;
        @(posedge clock_i) disable iff (!rstn_i)
        wd_expire |=> (timeout_flag_reg && !epp_busy_o);
    endproperty
    a_timeout_set: assert property (p_timeout_set) else $error("watchdog did not abort");

    sequence s_status_read_end;
        read_active_reg && host_rd_end_i && !timeout_clear_mode_i && !wd_expire;
    endsequence
    property p_read_clear;
        @(posedge clock_i) disable iff (!rstn_i)
        s_status_read_end |=> !timeout_flag_reg;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("timeout not cleared by read");

    property p_ctrl_top;
        @(posedge clock_i) disable iff (!rstn_i)
        (host_rd_i && hit && off == ppc_pkg::OFF_CONTROL) |=> (host_rdata_o[7:6] == 2'b00);
    endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");

    property p_no_hit;
        @(posedge clock_i) disable iff (!rstn_i)
        (host_rd_i && !hit) |=> !host_hit_o;
    endproperty
    a_no_hit: assert property (p_no_hit) else $error("answered outside window");

    // Status read fields: fixed zeros, pin levels, inverted busy, timeout hidden outside EPP
    sequence s_status_rd;
        host_rd_i && hit && off == ppc_pkg::OFF_STATUS;
    endsequence
    property p_status_zero;
        @(posedge clock_i) disable iff (!rstn_i)
        s_status_rd |=> (host_rdata_o[ppc_pkg::ST_FAULT-1:ppc_pkg::ST_TIMEOUT+1] == 2'b00);
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status bits one and two set");
    property p_status_levels;
        @(posedge clock_i) disable iff (!rstn_i)
        s_status_rd |=> (host_rdata_o[ppc_pkg::ST_ACK:ppc_pkg::ST_FAULT] ==
            $past({ack_in_level_i, paper_out_level_i, online_in_level_i, fault_in_level_i}));
    endproperty
    a_status_levels: assert property (p_status_levels) else $error("status pin levels wrong");
    property p_status_ready;
        @(posedge clock_i) disable iff (!rstn_i)
        s_status_rd |=> (host_rdata_o[ppc_pkg::ST_READY] == !$past(busy_in_i));
    endproperty
    a_status_ready: assert property (p_status_ready) else $error("ready bit not inverted busy");
    property p_status_tmo_hidden;
        @(posedge clock_i) disable iff (!rstn_i)
        (host_rd_i && hit && off == ppc_pkg::OFF_STATUS && !epp_mode) |=> !host_rdata_o[ppc_pkg::ST_TIMEOUT];
    endproperty
    a_status_tmo_hidden: assert property (p_status_tmo_hidden) else $error("timeout bit shown outside EPP");
    property p_status_hold;
        @(posedge clock_i) disable iff (!rstn_i)
        (read_active_reg && !host_rd_i) |=> $stable(host_rdata_o);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status snapshot not held");

    // Remaining control pins follow their bits one edge later
    property p_autofeed;
        @(posedge clock_i) disable iff (!rstn_i)
        ##1 (autofeed_out_low_o == !$past(peripheral_control_reg[ppc_pkg::CT_AUTOFEED]));
    endproperty
    a_autofeed: assert property (p_autofeed) else $error("autofeed pin wrong");
    property p_select;
        @(posedge clock_i) disable iff (!rstn_i)
        ##1 (select_request_out_o == !$past(peripheral_control_reg[ppc_pkg::CT_SELECT]));
    endproperty
    a_select: assert property (p_select) else $error("select pin wrong");
    property p_ctrl_write;
        @(posedge clock_i) disable iff (!rstn_i)
        (host_wr_i && hit && off == ppc_pkg::OFF_CONTROL) |=>
            (peripheral_control_reg == $past(host_wdata_i[ppc_pkg::CT_WIDTH-1:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // Data port: a write reaches the pins two edges later, a read shows the live lines
    sequence s_data_write;
        (host_wr_i && hit && off == ppc_pkg::OFF_DATA) ##1 !epp_busy_o;
    endsequence
    property p_data_write;
        @(posedge clock_i) disable iff (!rstn_i)
        s_data_write |=> (port_data_lines_o == $past(host_wdata_i, 2));
    endproperty
    a_data_write: assert property (p_data_write) else $error("data byte not on pins");
    property p_data_read;
        @(posedge clock_i) disable iff (!rstn_i)
        (host_rd_i && hit && off == ppc_pkg::OFF_DATA) |=> (host_rdata_o == $past(port_data_lines_i));
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read not live");

    // Timeout flag: reset always clears, a written one clears, a written zero never does
    property p_flag_reset;
        @(posedge clock_i) !rstn_i |=> !timeout_flag_reg;
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("reset left timeout flag");
    sequence s_status_write;
        timeout_clear_mode_i && host_wr_i && hit && epp_mode && off == ppc_pkg::OFF_STATUS;
    endsequence
    property p_write_one;
        @(posedge clock_i) disable iff (!rstn_i)
        (s_status_write ##0 (host_wdata_i[ppc_pkg::ST_TIMEOUT] && !wd_expire)) |=> !timeout_flag_reg;
    endproperty
    a_write_one: assert property (p_write_one) else $error("write of one kept flag");
    property p_write_zero;
        @(posedge clock_i) disable iff (!rstn_i)
        (s_status_write ##0 (!host_wdata_i[ppc_pkg::ST_TIMEOUT] && timeout_flag_reg)) |=> timeout_flag_reg;
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write of zero cleared flag");

    // EPP cycle starts on an idle access and ends once the peripheral lets go of wait
    sequence s_epp_start;
        (host_wr_i || host_rd_i) && hit && epp_reg_sel && !epp_busy_o;
    endsequence
    property p_epp_start;
        @(posedge clock_i) disable iff (!rstn_i)
        s_epp_start |=> epp_busy_o;
    endproperty
    a_epp_start: assert property (p_epp_start) else $error("EPP cycle not started");
    property p_epp_end;
        @(posedge clock_i) disable iff (!rstn_i)
        (epp_busy_o && !epp_wait_low_i) |=> !epp_busy_o;
    endproperty
    a_epp_end: assert property (p_epp_end) else $error("EPP cycle did not end");
endmodule // ppc_regs
`default_nettype wire

// File: pkg/ppc_pkg.sv
// Purpose: Shared constants for the printer port register front end
// Assumes: Byte-wide host I/O port, 50 MHz system clock
// Notes: Offsets are byte offsets from the configured base address
package ppc_pkg;
    // Port offsets within the eight-byte window
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_STATUS = 3'h1;
    localparam logic [2:0] OFF_CONTROL = 3'h2;
    localparam logic [2:0] OFF_EPP_ADDR = 3'h3;
    localparam logic [2:0] OFF_EPP_DATA0 = 3'h4;
    localparam logic [2:0] OFF_EPP_DATA3 = 3'h7;
    localparam int WINDOW_BYTES = 8;
    // Status bit positions
    localparam int ST_TIMEOUT = 0;
    localparam int ST_FAULT = 3;
    localparam int ST_ONLINE = 4;
    localparam int ST_PAPER = 5;
    localparam int ST_ACK = 6;
    localparam int ST_READY = 7;
    // Control bit positions
    localparam int CT_STROBE = 0;
    localparam int CT_AUTOFEED = 1;
    localparam int CT_PERIPH_RESET = 2;
    localparam int CT_SELECT = 3;
    localparam int CT_IRQ_EN = 4;
    localparam int CT_DIRECTION = 5;
    localparam int CT_WIDTH = 6;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    // Port modes
    typedef enum logic [1:0] {
        PPC_MODE_PRINTER = 2'b00,
        PPC_MODE_BIDIR = 2'b01,
        PPC_MODE_EPP = 2'b10,
        PPC_MODE_ECP = 2'b11
    } ppc_mode_t;
    // Watchdog timing
    localparam int CLOCK_MHZ = 50;
    localparam int EPP_TIMEOUT_US = 10;
    localparam int EPP_TIMEOUT_CYCLES = EPP_TIMEOUT_US * CLOCK_MHZ;
    localparam int WD_WIDTH = 10;
endpackage

// File: verif/ppc_printer_model.sv
// Purpose: Behavioural peripheral on the cable side of the printer port
// Assumes: The port's own byte is on the wire whenever it drives the lines
// Notes: Stall holds the EPP wait without end so the watchdog must act
`timescale 1ns/100ps
`default_nettype none
module ppc_printer_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Port side
    input wire logic [7:0] port_data_i,
    input wire logic port_oe_i,
    input wire logic epp_busy_i,
    // Bench controls
    input wire logic [7:0] drive_byte_i,
    input wire logic stall_i,
    // Cable levels
    output logic [7:0] lines_o,
    output logic wait_low_o
);
    logic [3:0] wait_cnt_reg;
    // Wait held three cycles into each EPP cycle: slow, yet legal
    always_ff @(posedge clock_i) begin
        if (!rstn_i || !epp_busy_i) begin
            wait_cnt_reg <= 4'h0;
        end else if (wait_cnt_reg != 4'hF) begin
            wait_cnt_reg <= wait_cnt_reg + 4'h1;
        end
    end
    // Wire level: the port's byte when it drives, else the peripheral's
    assign lines_o = port_oe_i ? port_data_i : drive_byte_i;
    assign wait_low_o = epp_busy_i && (stall_i || wait_cnt_reg < 4'h3);
endmodule // ppc_printer_model
`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the printer port register front end
// Assumes: Host strobes are one-cycle pulses taken at the rising edge
// Notes: Watchdog runs its full 500 cycles; no shortening parameter exists
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [15:0] BASE = 16'h0240;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] mode = 2'h0;
    logic clr_mode = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, rd_end = 1'b0, stall = 1'b0, hit, got;
    logic [7:0] wdata = 8'h00, drive_byte = 8'h3C, lines, dout, rdata, v;
    logic fault = 1'b1, online = 1'b0, paper = 1'b0, ack = 1'b1, busy = 1'b0;
    logic oe, strobe_n, afd_n, init, sel_n, irq, ebusy, wait_low;
    int miscompares = 0;
    int tests_run = 0;
    logic [7:0] ctl_vals [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hFF, 8'h00};
    ppc_regs dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .base_addr_i(BASE), .mode_i(mode),
        .timeout_clear_mode_i(clr_mode), .host_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd),
        .host_rd_end_i(rd_end), .host_wdata_i(wdata), .host_rdata_o(rdata), .host_hit_o(hit),
        .port_data_lines_i(lines), .port_data_lines_o(dout), .port_data_lines_oe_o(oe),
        .fault_in_level_i(fault), .online_in_level_i(online), .paper_out_level_i(paper),
        .ack_in_level_i(ack), .busy_in_i(busy), .epp_wait_low_i(wait_low),
        .strobe_out_low_o(strobe_n), .autofeed_out_low_o(afd_n), .peripheral_reset_out_o(init),
        .select_request_out_o(sel_n), .port_irq_o(irq), .epp_busy_o(ebusy));
    ppc_printer_model peer_u (.clock_i(clock_i), .rstn_i(rstn_i), .port_data_i(dout),
        .port_oe_i(oe), .epp_busy_i(ebusy), .drive_byte_i(drive_byte), .stall_i(stall),
        .lines_o(lines), .wait_low_o(wait_low));
    // Free-running 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Write, then let the pins follow two edges later
    task automatic wr_reg(input logic [2:0] off, input logic [7:0] d);
        @(posedge clock_i);
        addr <= BASE + 16'(off);
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic rd_start(input logic [15:0] a);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
    endtask
    task automatic rd_fin();
        @(posedge clock_i);
        rd_end <= 1'b1;
        @(posedge clock_i);
        rd_end <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] off, input logic [7:0] mask, input logic [7:0] exp);
        rd_start(BASE + 16'(off));
        chk(rdata & mask, exp);
        rd_fin();
    endtask
    // Raise an ack pulse and note any interrupt in the next cycles
    task automatic ack_pulse();
        got = 1'b0;
        @(posedge clock_i);
        ack <= 1'b0;
        @(posedge clock_i);
        ack <= 1'b1;
        repeat (4) begin
            @(posedge clock_i);
            #1;
            got |= irq;
        end
    endtask
    // EPP data write that waits out the cycle under a bound
    task automatic epp_go();
        int n;
        n = 0;
        wr_reg(3'h4, 8'h5A);
        chk({ebusy, dout[6:0]}, 8'hDA);
        while (ebusy !== 1'b0 && n < 700) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk({7'h00, ebusy}, 8'h00);
    endtask
    // Watchdog far beyond the expected few thousand cycles
    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(dout, 8'h00);
        chk({oe, strobe_n, afd_n, init, sel_n, irq, 2'h0}, 8'hE8);
        rd_chk(3'h2, 8'hFF, 8'h00);
        $display("test reset done");
        wr_reg(3'h0, 8'hA5);
        chk(dout, 8'hA5);
        rd_chk(3'h0, 8'hFF, 8'hA5);
        foreach (ctl_vals[i]) begin
            v = ctl_vals[i];
            wr_reg(3'h2, v);
            chk({oe, strobe_n, afd_n, init, sel_n, 3'h0}, {1'b1, ~v[0], ~v[1], v[2], ~v[3], 3'h0});
            rd_chk(3'h2, 8'hFF, v & 8'h3F);
        end
        mode <= 2'h1;
        wr_reg(3'h2, 8'h20);
        chk({7'h00, oe}, 8'h00);
        rd_chk(3'h0, 8'hFF, 8'h3C);
        wr_reg(3'h2, 8'h00);
        chk({oe, 7'h00} | (dout ^ 8'hA5), 8'h80);
        mode <= 2'h0;
        $display("test data and control done");
        for (int i = 0; i < 32; i++) begin
            @(posedge clock_i);
            {busy, ack, paper, online, fault} <= 5'(i);
            rd_chk(3'h1, 8'hFF, {~i[4], i[3], i[2], i[1], i[0], 3'h0});
        end
        rd_start(BASE + 16'h0001);
        v = rdata;
        @(posedge clock_i);
        {busy, ack, paper, online, fault} <= ~{busy, ack, paper, online, fault};
        repeat (3) @(posedge clock_i);
        #1;
        chk(rdata, v);
        rd_fin();
        $display("test status done");
        wr_reg(3'h2, 8'h10);
        ack_pulse();
        chk({7'h00, got}, 8'h01);
        wr_reg(3'h2, 8'h00);
        ack_pulse();
        chk({7'h00, got}, 8'h00);
        $display("test interrupt done");
        rd_start(BASE + 16'h0008);
        chk({hit, rdata[6:0]}, 8'h00);
        rd_start(BASE - 16'h0001);
        chk({7'h00, hit}, 8'h00);
        rd_start(BASE + 16'h0004);
        chk({7'h00, hit}, 8'h00);
        @(posedge clock_i);
        mode <= 2'h2;
        rd_start(BASE + 16'h0003);
        chk({7'h00, hit}, 8'h01);
        // That read opened an EPP cycle; an EPP port access before it ends would be ignored
        repeat (8) @(posedge clock_i);
        $display("test decode done");
        epp_go();
        rd_chk(3'h1, 8'h01, 8'h00);
        stall <= 1'b1;
        epp_go();
        rd_chk(3'h1, 8'h01, 8'h01);
        rd_chk(3'h1, 8'h01, 8'h00);
        clr_mode <= 1'b1;
        epp_go();
        rd_chk(3'h1, 8'h01, 8'h01);
        wr_reg(3'h1, 8'h00);
        rd_chk(3'h1, 8'h01, 8'h01);
        wr_reg(3'h1, 8'h01);
        rd_chk(3'h1, 8'h01, 8'h00);
        epp_go();
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_chk(3'h1, 8'h01, 8'h00);
        $display("test timeout done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
